// [bench/dog_checker_sva.sv]
module dog_checker
    import dog_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_BASE
)
(
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              chip_reset,
    input wire logic              kick_instruction,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic              wr_en,
    input wire logic              rd_en,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic              dog_reset_pulse,
    input wire logic              dog_enabled,
    input wire logic              irq
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MIN_GAP = (TIMEOUT_CYCLES - 1) * OSC_DIV;
    logic [CNT_W-1:0] since_r;
    logic             cw;
    assign cw = wr_en && addr == OFF_CONTROL && !chip_reset;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Restarts with the count; a pulse sooner than the shortest period is premature
    always_ff @(posedge clk) begin
        if (!rst_n || chip_reset || kick_instruction || !dog_enabled || dog_reset_pulse) begin
            since_r <= '0;
        end else if (since_r != '1) begin
            since_r <= since_r + 1'b1;
        end
    end
    AST_PULSE_ONE: assert property (dog_reset_pulse |=> !dog_reset_pulse)
        else $error("reset pulse longer than one cycle");
    AST_CTRL_HI_ZERO: assert property (rd_en && addr == OFF_CONTROL |=> rdata[7:5] == 3'h0)
        else $error("control bits 7..5 not zero");
    AST_EN_SET: assert property (cw && wdata[POS_ENABLE] |=> dog_enabled)
        else $error("enable write ignored");
    AST_EN_HOLD: assert property (dog_enabled && !chip_reset && !(wr_en && addr == OFF_CONTROL)
        |=> dog_enabled)
        else $error("enable dropped without a write");
    AST_LATE_OFF: assert property (cw && wdata[4:3] == 2'h3 ##1 (!wr_en && !chip_reset)[*4] ##1
        (cw && wdata[4:3] == 2'h0) |=> dog_enabled)
        else $error("disable accepted after the window");
    AST_WINDOW_OFF: assert property (cw && wdata[4:3] == 2'h3 ##1 (!wr_en && !chip_reset)[*3] ##1
        (cw && !wdata[POS_ENABLE]) |=> !dog_enabled)
        else $error("disable refused inside the window");
    AST_CHIP_RESET: assert property (chip_reset |=> !dog_enabled)
        else $error("chip reset left watchdog enabled");
    AST_IDLE_QUIET: assert property ((!dog_enabled)[*4] |-> !dog_reset_pulse)
        else $error("pulse while disabled");
    AST_KICK_GAP: assert property (dog_reset_pulse |-> since_r >= MIN_GAP)
        else $error("pulse before the period elapsed");
endmodule

bind watchdog_timeout_reset dog_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk_i (.clk(clk), .rst_n(rst_n),
    .chip_reset(chip_reset), .kick_instruction(kick_instruction), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .dog_reset_pulse(dog_reset_pulse), .dog_enabled(dog_enabled), .irq(irq));

// [bench/testbench.sv]
module testbench;
    import dog_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    // Shortened period keeps the run small; expectations scale from it
    localparam int T = 4;
    logic              clk, rst_n, chip_reset, kick, wr_en, rd_en, pulse, dog_en, irq;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    int                n_mismatch, num_checks, cyc;
    watchdog_timeout_reset #(.TIMEOUT_CYCLES(T)) uut (.clk(clk), .rst_n(rst_n), .chip_reset(chip_reset),
        .kick_instruction(kick), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .dog_reset_pulse(pulse), .dog_enabled(dog_en), .irq(irq));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk($sformatf("reg %0h", a), exp, rdata);
    endtask
    task automatic wait_pulse(input int lim, input logic must);
        cyc = 0;
        #1;
        while (pulse !== 1'b1 && cyc < lim) begin
            @(posedge clk);
            #1;
            cyc++;
        end
        if (must && pulse !== 1'b1) begin
            n_mismatch++;
            $display("wrong value pulse: expected 1, seen %b", pulse);
            summarize();
        end
    endtask
    task automatic pulse_chip_reset();
        @(posedge clk);
        chip_reset <= 1'b1;
        @(posedge clk);
        chip_reset <= 1'b0;
    endtask
    initial begin
        rst_n = 1'b0;
        chip_reset = 1'b0;
        kick = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = '0;
        wdata = '0;
        n_mismatch = 0;
        num_checks = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFF_CONTROL, 8'h00);
        chk("enabled", 8'h00, {7'h0, dog_en});
        $display("reset test done");
        wr(OFF_CONTROL, 8'hFF);
        rd(OFF_CONTROL, 8'h1F);
        repeat (2) @(posedge clk);
        wr(4'hF, 8'h00);
        rd(4'hF, 8'h00);
        rd(OFF_CONTROL, 8'h0F);
        wr(OFF_CONTROL, 8'h18);
        repeat (3) @(posedge clk);
        wr(OFF_CONTROL, 8'h00);
        rd(OFF_CONTROL, 8'h08);
        wr(OFF_CONTROL, 8'h18);
        repeat (2) @(posedge clk);
        wr(OFF_CONTROL, 8'h07);
        rd(OFF_CONTROL, 8'h07);
        rd(OFF_IRQ_STATUS, 8'h02);
        wr(OFF_IRQ_CLEAR, 8'h03);
        rd(OFF_IRQ_STATUS, 8'h00);
        $display("unlock test done");
        for (int s = 0; s < 2; s++) begin
            wr(OFF_IRQ_ENABLE, 8'(s));
            wr(OFF_CONTROL, 8'h08 | 8'(s));
            wait_pulse((T << s) * OSC_DIV + 10, 1'b1);
            chk("period", 8'h01, {7'h0, cyc >= ((T << s) - 1) * OSC_DIV});
            rd(OFF_RST_STATUS, 8'h08);
            rd(OFF_IRQ_STATUS, 8'h01);
            chk("irq", 8'(s), {7'h0, irq});
            pulse_chip_reset();
            rd(OFF_CONTROL, 8'h00);
            rd(OFF_RST_STATUS, 8'h08);
            wr(OFF_RST_STATUS, 8'h00);
            rd(OFF_RST_STATUS, 8'h00);
            wr(OFF_IRQ_CLEAR, 8'h01);
            rd(OFF_IRQ_ENABLE, 8'(s));
            chk("irq cleared", 8'h00, {7'h0, irq});
        end
        $display("timeout test done");
        wr(OFF_CONTROL, 8'h08);
        for (int k = 0; k < 3; k++) begin
            wait_pulse(3 * OSC_DIV, 1'b0);
            chk("early pulse", 8'h00, {7'h0, pulse});
            @(posedge clk);
            kick <= 1'b1;
            @(posedge clk);
            kick <= 1'b0;
        end
        wait_pulse(T * OSC_DIV + 10, 1'b1);
        pulse_chip_reset();
        $display("kick test done");
        summarize();
    end
endmodule

// [hw/dog_period_counter.sv]
module dog_period_counter
    import dog_pkg::*;
#(
    parameter int BASE = TIMEOUT_BASE
)
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       clear,
    input  wire logic       tick,
    input  wire logic       run,
    input  wire logic [2:0] sel,
    output logic            expire
);

    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] last;

    // Period doubles per select code
    assign last = CNT_W'(BASE) << sel;

    always_ff @(posedge clk) begin
        if (!rst_n || clear || !run) begin
            count_r <= '0;
            expire  <= 1'b0;
        // Compare with >= so that shrinking the period mid-count expires on the
        // next tick instead of running on until the counter wraps.
        end else if (tick && (count_r >= last - CNT_W'(1))) begin
            count_r <= '0;
            expire  <= 1'b1;
        end else begin
            if (tick) begin
                count_r <= count_r + CNT_W'(1);
            end
            expire <= 1'b0;
        end
    end

endmodule

// [hw/dog_pkg.sv]
package dog_pkg;

    // Register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFF_CONTROL    = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_RST_STATUS = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR  = 4'h3;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 4'h4;

    // Control register field positions
    localparam int POS_SEL_LO = 0;
    localparam int POS_SEL_HI = 2;
    localparam int POS_ENABLE = 3;
    localparam int POS_UNLOCK = 4;

    // Reset status register: position of the watchdog reset flag
    localparam int POS_DOG_FLAG = 3;

    // Interrupt status bits
    localparam int IRQ_W          = 2;
    localparam int IRQ_POS_EXPIRE = 0;
    localparam int IRQ_POS_OFF    = 1;

    // Reset values
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

    // Timing
    localparam longint CLK_FREQ_HZ   = 100_000_000;
    localparam longint OSC_FREQ_HZ   = 1_000_000;
    localparam int     OSC_DIV       = int'(CLK_FREQ_HZ / OSC_FREQ_HZ);
    localparam int     OSC_DIV_W     = 7;
    localparam int     UNLOCK_CYCLES = 4;
    localparam int     UNLOCK_W      = 3;
    localparam int     TIMEOUT_BASE  = 16_384;
    localparam int     SEL_MAX       = 7;
    localparam int     CNT_W         = 22;

    typedef struct packed {
        logic       turn_off_unlock;
        logic       dog_enable_bit;
        logic [2:0] timeout_select;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = '0;

endpackage

// [hw/dog_unlock_window.sv]
module dog_unlock_window
    import dog_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic clear,
    input  wire logic open,
    output logic      active
);

    logic [UNLOCK_W-1:0] left_r;

    always_ff @(posedge clk) begin
        if (!rst_n || clear) begin
            left_r <= '0;
        end else if (open) begin
            left_r <= UNLOCK_W'(UNLOCK_CYCLES);
        end else if (left_r != '0) begin
            left_r <= left_r - UNLOCK_W'(1);
        end
    end

    assign active = (left_r != '0);

endmodule

// [hw/watchdog_timeout_reset.sv]
// Functional notes
// - Watchdog counter advances on a 1 MHz oscillator tick, not the core clock.
// - The kick instruction restarts the watchdog counter from zero.
// - Counter is cleared while the watchdog is disabled and on any chip reset.
// - Enabled watchdog reaching its period without a kick resets the device.
// - Control register bits 7 to 5 always read zero.
// - Enable bit set by writing one; cleared by a chip reset, or by a write only while the unlock bit is one.
// - Unlock bit clears itself four clock cycles after being written one.
// - Select code 0 gives 16384 oscillator cycles, doubling up to 2097152.
// - All implemented control bits reset to zero: disabled, shortest period.
// - Timeout emits a reset pulse exactly one core clock cycle long.
// - Watchdog reset sets a flag cleared only by power-on reset or writing zero.
//
// The placing of the registers and the address-and-strobe port were decided locally.
module watchdog_timeout_reset
    import dog_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_BASE
)
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              chip_reset,
    input  wire logic              kick_instruction,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    output logic      [DATA_W-1:0] rdata,
    output logic                   dog_reset_pulse,
    output logic                   dog_enabled,
    output logic                   irq
);

    ctrl_t                ctrl_view;
    logic                 enable_r;
    logic [2:0]           select_r;
    logic                 unlock_active;
    logic                 ctrl_wr;
    logic                 rst_status_wr;
    logic                 irq_clear_wr;
    logic                 irq_enable_wr;
    logic                 unlock_open;
    logic                 osc_wrap;
    logic                 wr_unlock;
    logic                 wr_enable;
    logic [2:0]           wr_select;
    logic                 disable_now;
    logic [OSC_DIV_W-1:0] osc_div_r;
    logic                 osc_tick_r;
    logic                 expire;
    logic                 pulse_r;
    logic                 dog_flag_r;
    logic [IRQ_W-1:0]     irq_status_r;
    logic [IRQ_W-1:0]     irq_enable_r;
    logic [IRQ_W-1:0]     irq_set;
    logic [IRQ_W-1:0]     irq_clr;
    logic [DATA_W-1:0]    rdata_r;
    logic [DATA_W-1:0]    read_val;

    // Write decode
    assign ctrl_wr       = wr_en && (addr == OFF_CONTROL);
    assign rst_status_wr = wr_en && (addr == OFF_RST_STATUS);
    assign irq_clear_wr  = wr_en && (addr == OFF_IRQ_CLEAR);
    assign irq_enable_wr = wr_en && (addr == OFF_IRQ_ENABLE);
    assign wr_unlock     = wdata[POS_UNLOCK];
    assign wr_enable     = wdata[POS_ENABLE];
    assign wr_select     = wdata[POS_SEL_HI:POS_SEL_LO];

    // Disable only when the window was already open before this write; the
    // write that opens the window can never also stop the dog.
    assign disable_now = ctrl_wr && !wr_enable && unlock_active && enable_r;

    // Any control write with the unlock bit set (re)opens the window, even
    // without the enable bit, so a second unlock buys four more cycles.
    assign unlock_open = ctrl_wr && wr_unlock;

    // Oscillator stand-in: a 1 MHz tick divided from the core clock. Keeping it
    // in the core domain means kick, enable, select and the timeout all share
    // one clock, so nothing can tear across a boundary.
    assign osc_wrap = (osc_div_r == OSC_DIV_W'(OSC_DIV - 1));

    // Free-running from power-on reset only: a chip reset must not shift the
    // tick phase, just as it would not stop a separate oscillator.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            osc_div_r <= '0;
        end else if (osc_wrap) begin
            osc_div_r <= '0;
        end else begin
            osc_div_r <= osc_div_r + OSC_DIV_W'(1);
        end
    end

    // One tick per oscillator period, one core cycle wide
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            osc_tick_r <= 1'h0;
        end else begin
            osc_tick_r <= osc_wrap;
        end
    end

    // Unlock window
    dog_unlock_window u_unlock (
        .clk    (clk),
        .rst_n  (rst_n),
        .clear  (chip_reset),
        .open   (unlock_open),
        .active (unlock_active)
    );

    // Enable bit: set by any write of one, cleared only through the window.
    // A chip reset also drops it, which in turn clears the period counter.
    always_ff @(posedge clk) begin
        if (!rst_n || chip_reset) begin
            enable_r <= CTRL_RESET.dog_enable_bit;
        end else if (ctrl_wr && wr_enable) begin
            enable_r <= 1'h1;
        end else if (disable_now) begin
            enable_r <= 1'h0;
        end
    end

    // Select field: accepted at any time. A period shorter than the count
    // already reached expires on the next tick, so kick after changing it.
    always_ff @(posedge clk) begin
        if (!rst_n || chip_reset) begin
            select_r <= CTRL_RESET.timeout_select;
        end else if (ctrl_wr) begin
            select_r <= wr_select;
        end
    end

    // Register view of the control fields; the unlock bit lives in the window counter
    always_comb begin
        ctrl_view                 = CTRL_RESET;
        ctrl_view.turn_off_unlock = unlock_active;
        ctrl_view.dog_enable_bit  = enable_r;
        ctrl_view.timeout_select  = select_r;
    end

    // Period counter: restarted by kick, disable or chip reset
    dog_period_counter #(
        .BASE (TIMEOUT_CYCLES)
    ) u_period (
        .clk    (clk),
        .rst_n  (rst_n),
        .clear  (kick_instruction || chip_reset),
        .tick   (osc_tick_r),
        .run    (ctrl_view.dog_enable_bit),
        .sel    (ctrl_view.timeout_select),
        .expire (expire)
    );

    // One-cycle reset request; the counter restarts after it, so a second pulse
    // needs a full period even if the system ignores the first one.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pulse_r <= 1'b0;
        end else begin
            pulse_r <= expire && !kick_instruction && !chip_reset;
        end
    end

    assign dog_reset_pulse = pulse_r;
    assign dog_enabled     = ctrl_view.dog_enable_bit;

    // Reset status flag survives chip resets; only power-on or software clears it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dog_flag_r <= 1'b0;
        end else if (pulse_r) begin
            dog_flag_r <= 1'b1;
        end else if (rst_status_wr && !wdata[POS_DOG_FLAG]) begin
            dog_flag_r <= 1'b0;
        end
    end

    // Interrupt events
    always_comb begin
        irq_set                 = '0;
        irq_set[IRQ_POS_EXPIRE] = pulse_r;
        irq_set[IRQ_POS_OFF]    = disable_now;
        irq_clr                 = '0;
        if (irq_clear_wr) begin
            irq_clr = wdata[IRQ_W-1:0];
        end
    end

    // Sticky status, one bit per event; set wins over a clear in the same
    // cycle so an event that lands on the clear write is never lost.
    for (genvar i = 0; i < IRQ_W; i++) begin : g_irq_bit
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                irq_status_r[i] <= IRQ_RESET[i];
            end else if (irq_set[i]) begin
                irq_status_r[i] <= 1'h1;
            end else if (irq_clr[i]) begin
                irq_status_r[i] <= 1'h0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_enable_r <= IRQ_RESET;
        end else if (irq_enable_wr) begin
            irq_enable_r <= wdata[IRQ_W-1:0];
        end
    end

    assign irq = |(irq_status_r & irq_enable_r);

    // Read mux; unmapped and write-only offsets read zero
    always_comb begin
        read_val = '0;
        unique case (addr)
            OFF_CONTROL: begin
                read_val[POS_UNLOCK]            = ctrl_view.turn_off_unlock;
                read_val[POS_ENABLE]            = ctrl_view.dog_enable_bit;
                read_val[POS_SEL_HI:POS_SEL_LO] = ctrl_view.timeout_select;
            end
            OFF_RST_STATUS: begin
                read_val[POS_DOG_FLAG] = dog_flag_r;
            end
            OFF_IRQ_STATUS: begin
                read_val[IRQ_W-1:0] = irq_status_r;
            end
            OFF_IRQ_ENABLE: begin
                read_val[IRQ_W-1:0] = irq_enable_r;
            end
            default: begin
                read_val = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_r <= '0;
        end else if (rd_en) begin
            rdata_r <= read_val;
        end else begin
            rdata_r <= '0;
        end
    end

    assign rdata = rdata_r;

endmodule
